/* fpps_sequencer.sv */
// Programmer-side sequencer that fuses and verifies a bipolar PROM bit by bit
//
// Functional notes
// - Force only one output per cycle; all other outputs stay undriven.
// - Order: address with chip off, supply up, output up, pulse, release.
// - At least 100 ns between any two consecutive programming steps.
// - Enable pulse starts at least 100 ns after forced output is up.
// - Enable pulse lasts 9 to 11 us, 10 us nominal.
// - Elevated supply stays on at most 25 % of the time.
// - Elevated supply and forcing level between 10.5 V and 11.5 V.
// - After each pulse verify the bit at low and at high supply; the five extra pulses go unverified.
// - Low verify supply 4.2-4.4 V, high verify supply 5.8-6.2 V.
// - Up to ten pulse-and-verify rounds, stop once the bit verifies.
// - After the first good verify apply five more pulses.
// - Address and enable stay at plain logic levels throughout.
// - Asynchronous registered parts use exactly the same sequence.
// - Synchronous registered parts need the enable register path blocked.
`timescale 1ns/1ps

module fpps_sequencer
    import fpps_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              arst_n,
    input  wire fpps_load_t        load,
    input  wire logic              start,
    input  wire logic              sync_variant,
    input  wire logic [DATA_W-1:0] sense,
    output fpps_pins_t             pins,
    output fpps_status_t           status
);

    ////////////////////////////////////////////////////////////////////////////
    // Pattern store and sense synchroniser

    logic [DATA_W-1:0] pattern [WORDS];
    logic [DATA_W-1:0] sense_meta;
    logic [DATA_W-1:0] sense_sync;

    always_ff @(posedge clock)
    begin
        if (load.valid && status.busy == 1'b0)
            pattern[load.addr] <= load.data;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sense_meta <= '0;
            sense_sync <= '0;
        end
        else
        begin
            sense_meta <= sense;
            sense_sync <= sense_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state

    fpps_state_t       state;
    fpps_state_t       next_state;
    logic [ADDR_W-1:0] addr;
    logic [BIT_W-1:0]  bit_idx;
    logic [WAIT_W-1:0] wait_cnt;
    logic [WAIT_W-1:0] on_cnt;
    logic [CNT_W-1:0]  pulse_cnt;
    logic [CNT_W-1:0]  extra_left;
    logic              in_extra;
    logic              lo_ok;
    logic              passed;

    wire               expired   = (wait_cnt == WAIT_ZERO);
    wire               want_bit  = pattern[addr][bit_idx];
    wire               last_pos  = (addr == LAST_ADDR) && (bit_idx == LAST_BIT);
    wire               sense_bit = sense_sync[bit_idx];
    wire               advance   = ((state == S_SCAN) && !want_bit) || ((state == S_NEXT) && expired);
    wire               entering  = (next_state != state);
    wire               give_up   = (state == S_VER_END) && expired && !passed && (pulse_cnt == MAX_PULSES);
    wire               pass_now  = (state == S_VHI_RD) && expired && lo_ok && sense_bit;
    wire               pulse_in  = (next_state == S_PULSE) && entering;

    always_comb
    begin
        next_state = state;
        unique case (state)
            S_IDLE:    if (start) next_state = S_SCAN;
            S_SCAN:    if (want_bit) next_state = S_SETUP;
                       else if (last_pos) next_state = S_IDLE;
            S_SETUP:   if (expired) next_state = S_VCC_UP;
            S_VCC_UP:  if (expired) next_state = S_FORCE;
            S_FORCE:   if (expired) next_state = S_PULSE;
            S_PULSE:   if (expired) next_state = S_RELEASE;
            S_RELEASE: if (expired) next_state = S_UNFORCE;
            S_UNFORCE: if (expired) next_state = S_COOL;
            S_COOL:    if (expired) next_state = in_extra ? ((extra_left == CNT_ZERO) ? S_NEXT : S_VCC_UP)
                                                          : S_VLO_SET;
            S_VLO_SET: if (expired) next_state = S_VLO_RD;
            S_VLO_RD:  if (expired) next_state = S_VHI_SET;
            S_VHI_SET: if (expired) next_state = S_VHI_RD;
            S_VHI_RD:  if (expired) next_state = S_VER_END;
            S_VER_END: if (expired) next_state = give_up ? S_NEXT : S_VCC_UP;
            S_NEXT:    if (expired) next_state = last_pos ? S_IDLE : S_SCAN;
        endcase
    end

    // Cool-down tracks the on time just spent; on_cnt lags the supply by one edge, hence the extra count
    wire [WAIT_W+1:0]  cool_full = OFF_RATIO * (on_cnt + WAIT_ONE);
    wire [WAIT_W-1:0]  cool_cyc  = (cool_full[WAIT_W-1:0] > GAP_CYC) ? cool_full[WAIT_W-1:0] - WAIT_ONE
                                                                     : GAP_CYC - WAIT_ONE;
    wire [WAIT_W-1:0]  next_wait = (next_state == S_COOL)  ? cool_cyc
                                 : (next_state == S_PULSE) ? PULSE_CYC - WAIT_ONE
                                 : GAP_CYC - WAIT_ONE;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state    <= S_IDLE;
            wait_cnt <= WAIT_ZERO;
        end
        else
        begin
            state    <= next_state;
            wait_cnt <= entering ? next_wait : (expired ? WAIT_ZERO : wait_cnt - WAIT_ONE);
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            addr    <= ADDR_ZERO;
            bit_idx <= BIT_ZERO;
        end
        else if (state == S_IDLE && start)
        begin
            addr    <= ADDR_ZERO;
            bit_idx <= BIT_ZERO;
        end
        else if (advance && !last_pos)
        begin
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == LAST_BIT)
                addr <= addr + 5'h01;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            on_cnt <= WAIT_ZERO;
        else if (next_state == S_VCC_UP && entering)
            on_cnt <= WAIT_ZERO;
        else if (pins.vcc_prog)
            on_cnt <= on_cnt + WAIT_ONE;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pulse_cnt  <= CNT_ZERO;
            extra_left <= CNT_ZERO;
            in_extra   <= 1'b0;
            lo_ok      <= 1'b0;
            passed     <= 1'b0;
        end
        else if (state == S_SCAN)
        begin
            pulse_cnt  <= CNT_ZERO;
            extra_left <= CNT_ZERO;
            in_extra   <= 1'b0;
            passed     <= 1'b0;
        end
        else
        begin
            if (pulse_in && !in_extra)
                pulse_cnt <= pulse_cnt + CNT_ONE;
            if (pulse_in && in_extra)
                extra_left <= extra_left - CNT_ONE;
            if (state == S_VLO_RD && expired)
                lo_ok <= sense_bit;
            if (pass_now)
                passed <= 1'b1;
            if (state == S_VER_END && expired && passed && !in_extra)
            begin
                in_extra   <= 1'b1;
                extra_left <= EXTRA_PULSES;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin and status registers

    wire               forcing      = (next_state == S_FORCE) || (next_state == S_PULSE) || (next_state == S_RELEASE);
    wire [DATA_W-1:0]  bit_onehot   = DATA_W'(1) << bit_idx;
    fpps_pins_t        next_pins;

    assign next_pins.addr               = addr;
    assign next_pins.ce_n               = !((next_state == S_PULSE) || (next_state == S_VLO_RD)
                                            || (next_state == S_VHI_RD));
    assign next_pins.vcc_prog           = (next_state == S_VCC_UP) || forcing
                                          || (next_state == S_UNFORCE);
    assign next_pins.vcc_ver_lo         = (next_state == S_VLO_SET) || (next_state == S_VLO_RD);
    assign next_pins.vcc_ver_hi         = (next_state == S_VHI_SET) || (next_state == S_VHI_RD);
    assign next_pins.output_force_level = forcing ? bit_onehot : '0;
    // Same sequence for every variant; only the register bypass differs
    assign next_pins.direct_en          = sync_variant && (next_state != S_IDLE);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pins   <= '{addr: ADDR_ZERO, ce_n: 1'b1, output_force_level: '0, default: 1'b0};
            status <= '0;
        end
        else
        begin
            pins        <= next_pins;
            status.busy <= (next_state != S_IDLE);
            if (state == S_IDLE && start)
            begin
                status.done <= 1'b0;
                status.fail <= 1'b0;
            end
            else if (next_state == S_IDLE && state != S_IDLE)
                status.done <= 1'b1;
            if (give_up && !status.fail)
            begin
                status.fail      <= 1'b1;
                status.fail_addr <= addr;
                status.fail_bit  <= bit_idx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    wire [11:0]        ctrl = {pins.ce_n, pins.vcc_prog, pins.vcc_ver_lo, pins.vcc_ver_hi,
                               pins.output_force_level};
    logic [WAIT_W-1:0] since_chg;
    logic [WAIT_W-1:0] low_cnt;
    logic [WAIT_W-1:0] on_run;
    logic [WAIT_W-1:0] off_run;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            since_chg <= WAIT_SAT;
            low_cnt   <= WAIT_ZERO;
            on_run    <= WAIT_ZERO;
            off_run   <= WAIT_ZERO;
        end
        else
        begin
            since_chg <= (ctrl != $past(ctrl)) ? WAIT_ZERO : ((since_chg == WAIT_SAT) ? WAIT_SAT : since_chg + WAIT_ONE);
            low_cnt   <= (!pins.ce_n && pins.vcc_prog) ? low_cnt + WAIT_ONE : WAIT_ZERO;
            on_run    <= pins.vcc_prog ? (($past(pins.vcc_prog)) ? on_run + WAIT_ONE : WAIT_ONE) : on_run;
            off_run   <= pins.vcc_prog ? WAIT_ZERO : ((off_run == WAIT_SAT) ? WAIT_SAT : off_run + WAIT_ONE);
        end
    end

    single_force_a: assert property ($onehot0(pins.output_force_level))
        else $error("more than one output forced");
    force_order_a: assert property ((pins.output_force_level != '0) |-> pins.vcc_prog)
        else $error("output forced without elevated supply");
    step_gap_a: assert property ((ctrl != $past(ctrl)) |-> (since_chg >= GAP_CYC - WAIT_ONE))
        else $error("programming steps closer than the minimum gap");
    force_lead_a: assert property (($fell(pins.ce_n) && pins.vcc_prog)
                                   |-> ($past(pins.output_force_level, GAP_CYC_I) != '0))
        else $error("enable pulse too soon after forcing");
    pulse_width_a: assert property (($rose(pins.ce_n) && pins.vcc_prog) |-> (low_cnt == PULSE_CYC))
        else $error("programming pulse width wrong");
    duty_cycle_a: assert property ($rose(pins.vcc_prog) |-> (off_run >= OFF_RATIO * $past(on_run)))
        else $error("elevated supply duty cycle exceeded");
    verify_levels_a: assert property ((pins.vcc_ver_lo || pins.vcc_ver_hi)
                                      |-> !(pins.vcc_ver_lo && pins.vcc_ver_hi) && !pins.vcc_prog)
        else $error("supply switches overlap");
    pulse_bound_a: assert property (pulse_cnt <= MAX_PULSES)
        else $error("too many pulses for one bit");
    extra_start_a: assert property ($rose(in_extra) |-> (extra_left == EXTRA_PULSES) && passed)
        else $error("extra pulses not armed after verify");
    direct_path_a: assert property (pins.direct_en |-> $past(sync_variant))
        else $error("register bypass without synchronous variant");
    fail_flag_a: assert property ($rose(status.fail) |-> $past(pulse_cnt) == MAX_PULSES)
        else $error("failure flagged before pulse limit");

    pass_first_c: cover property (pass_now && pulse_cnt == CNT_ONE);
    give_up_c:    cover property (give_up);
    extra_done_c: cover property (state == S_COOL && in_extra && extra_left == CNT_ZERO && expired);
    all_done_c:   cover property ($rose(status.done));

endmodule : fpps_sequencer

/* fpps_pkg.sv */
// Constants, types and timing figures for the fuse PROM programming sequencer
package fpps_pkg;

    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int BIT_W  = 3;
    localparam int WORDS  = 32;
    localparam int WAIT_W = 14;
    localparam int CNT_W  = 4;

    localparam int CLK_MHZ     = 200;
    localparam int STEP_GAP_NS = 100;
    localparam int PULSE_NS    = 10000;
    localparam int GAP_CYC_I   = (STEP_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC_I = (PULSE_NS * CLK_MHZ) / 1000;

    localparam logic [WAIT_W-1:0] GAP_CYC   = WAIT_W'(GAP_CYC_I);
    localparam logic [WAIT_W-1:0] PULSE_CYC = WAIT_W'(PULSE_CYC_I);
    localparam logic [WAIT_W-1:0] WAIT_ONE  = 14'h0001;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 14'h0000;
    localparam logic [WAIT_W-1:0] WAIT_SAT  = 14'h3fff;

    // Off time must be three times the on time to hold the supply at 25 % duty
    localparam logic [1:0]       OFF_RATIO    = 2'h3;
    localparam logic [CNT_W-1:0] MAX_PULSES   = 4'ha;
    localparam logic [CNT_W-1:0] EXTRA_PULSES = 4'h5;
    localparam logic [CNT_W-1:0] CNT_ZERO     = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE      = 4'h1;

    localparam logic [ADDR_W-1:0] LAST_ADDR = 5'h1f;
    localparam logic [BIT_W-1:0]  LAST_BIT  = 3'h7;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 5'h00;
    localparam logic [BIT_W-1:0]  BIT_ZERO  = 3'h0;

    typedef enum logic [14:0] {
        S_IDLE    = 15'h0001, S_SCAN    = 15'h0002, S_SETUP   = 15'h0004,
        S_VCC_UP  = 15'h0008, S_FORCE   = 15'h0010, S_PULSE   = 15'h0020,
        S_RELEASE = 15'h0040, S_UNFORCE = 15'h0080, S_COOL    = 15'h0100,
        S_VLO_SET = 15'h0200, S_VLO_RD  = 15'h0400, S_VHI_SET = 15'h0800,
        S_VHI_RD  = 15'h1000, S_VER_END = 15'h2000, S_NEXT    = 15'h4000
    } fpps_state_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fpps_load_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              ce_n;
        logic              vcc_prog;
        logic              vcc_ver_lo;
        logic              vcc_ver_hi;
        logic [DATA_W-1:0] output_force_level;
        logic              direct_en;
    } fpps_pins_t;

    typedef struct packed {
        logic              busy;
        logic              done;
        logic              fail;
        logic [ADDR_W-1:0] fail_addr;
        logic [BIT_W-1:0]  fail_bit;
    } fpps_status_t;

endpackage : fpps_pkg

/* fpps_prom_model.sv */
// Behavioural fuse PROM that fuses on enable pulses at elevated supply, of any width, and counts sequencing faults
`timescale 1ns/1ps

module fpps_prom_model
    import fpps_pkg::*;
#(
    parameter int NEED = 2
)
(
    input  wire logic         clock,
    input  wire logic         arst_n,
    input  wire fpps_pins_t   pins,
    output logic [DATA_W-1:0] sense,
    output logic [7:0]        pulses,
    output logic [7:0]        lo_reads,
    output logic [7:0]        hi_reads,
    output logic [7:0]        viol
);
    logic [DATA_W-1:0] mem [WORDS];
    fpps_pins_t        p;
    int                gap;
    int                low_len;
    int                on_len;
    int                off_len;
    logic              chg;
    logic [DATA_W-1:0] frc;

    initial
    begin
        for (int i = 0; i < WORDS; i++)
            mem[i] = 8'h00;
    end

    assign frc = pins.output_force_level;
    // Outputs of a disabled part float up to their pull-ups
    assign sense = (!pins.ce_n && !pins.vcc_prog) ? mem[pins.addr] : 8'hff;
    assign chg = {pins.ce_n, pins.vcc_prog, pins.vcc_ver_lo, pins.vcc_ver_hi, frc}
              != {p.ce_n, p.vcc_prog, p.vcc_ver_lo, p.vcc_ver_hi, p.output_force_level};

    always @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            p = '0;
            p.ce_n = 1'b1;
            gap = 100;
            low_len = 0;
            on_len = 0;
            off_len = 100000;
            pulses = '0;
            lo_reads = '0;
            hi_reads = '0;
            viol = '0;
        end
        else
        begin
            if (chg && gap < 19)
                viol++;
            gap = chg ? 0 : gap + 1;
            if ((frc & (frc - 8'h01)) != 8'h00)
                viol++;
            if ((frc != 8'h00 && !pins.vcc_prog) || (!pins.ce_n && pins.vcc_prog && frc == 8'h00))
                viol++;
            if (pins.vcc_prog && (pins.vcc_ver_lo || pins.vcc_ver_hi))
                viol++;
            if (pins.addr != p.addr && (!p.ce_n || p.vcc_prog))
                viol++;
            if (pins.vcc_prog && !p.vcc_prog)
            begin
                if (off_len < 3 * on_len)
                    viol++;
                on_len = 0;
                off_len = 0;
            end
            if (pins.vcc_prog)
                on_len++;
            else
                off_len++;
            if (!pins.ce_n)
                low_len++;
            else if (!p.ce_n)
            begin
                if (p.vcc_prog)
                begin
                    if (low_len < 1800 || low_len > 2200)
                        viol++;
                    pulses++;
                    // Fuse opens only from the NEED-th pulse on, whatever its width, so early verifies fail
                    if (pulses >= NEED)
                        mem[p.addr] |= p.output_force_level;
                end
                else if (p.vcc_ver_hi)
                    hi_reads++;
                else if (p.vcc_ver_lo)
                    lo_reads++;
                low_len = 0;
            end
            p = pins;
        end
    end
endmodule : fpps_prom_model

/* fuse_prom_program_sequencer_tb.sv */
// Self-checking testbench for the fuse PROM programming sequencer
`timescale 1ns/1ps

module fuse_prom_program_sequencer_tb;
    import fpps_pkg::*;

    localparam int NEED = 2;

    logic              clock;
    logic              arst_n;
    logic              start;
    logic              sync_variant;
    fpps_load_t        load;
    logic [DATA_W-1:0] sense;
    fpps_pins_t        pins;
    fpps_status_t      status;
    logic [7:0]        pulses;
    logic [7:0]        lo_reads;
    logic [7:0]        hi_reads;
    logic [7:0]        viol;
    int                bad_count;
    int                n_tests;
    logic [15:0]       exp_q [$];
    logic [ADDR_W-1:0] ta;
    logic [BIT_W-1:0]  tbit;
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] others;
    logic              done_seen;

    fpps_sequencer i_dut (
        .clock        (clock),
        .arst_n       (arst_n),
        .load         (load),
        .start        (start),
        .sync_variant (sync_variant),
        .sense        (sense),
        .pins         (pins),
        .status       (status)
    );

    fpps_prom_model #(.NEED(NEED)) i_prom (
        .clock    (clock),
        .arst_n   (arst_n),
        .pins     (pins),
        .sense    (sense),
        .pulses   (pulses),
        .lo_reads (lo_reads),
        .hi_reads (hi_reads),
        .viol     (viol)
    );

    always #2.5 clock = ~clock;

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic results;
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    // Result watcher: each completion consumes the oldest notes

    always @(posedge status.done)
    begin
        @(negedge clock);
        others = 8'h00;
        for (int a = 0; a < WORDS; a++)
            if (ADDR_W'(a) != ta)
                others |= i_prom.mem[a];
        chk("done fail", {6'h00, status.done, status.fail, status.fail_addr, status.fail_bit},
            exp_q.pop_front());
        chk("pulses", {8'h00, pulses}, exp_q.pop_front());
        chk("low reads", {8'h00, lo_reads}, exp_q.pop_front());
        chk("high reads", {8'h00, hi_reads}, exp_q.pop_front());
        chk("faults", {8'h00, viol}, exp_q.pop_front());
        chk("fused word", {8'h00, i_prom.mem[ta]}, exp_q.pop_front());
        chk("other words", {8'h00, others}, exp_q.pop_front());
        done_seen = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Driver

    initial
    begin
        clock = 1'b0;
        arst_n = 1'b0;
        start = 1'b0;
        sync_variant = 1'b0;
        load = '0;
        done_seen = 1'b0;
        bad_count = 0;
        n_tests = 0;
        void'($urandom(67));
        ta = ADDR_W'($urandom % WORDS);
        tbit = BIT_W'($urandom);
        word = DATA_W'(1) << tbit;
        repeat (6) @(negedge clock);
        arst_n = 1'b1;
        for (int a = 0; a < WORDS; a++)
        begin
            load.valid = 1'b1;
            load.addr = ADDR_W'(a);
            load.data = (ADDR_W'(a) == ta) ? word : 8'h00;
            @(negedge clock);
        end
        load.valid = 1'b0;
        sync_variant = 1'($urandom);
        // One target bit that fuses on its second pulse, then five extras
        exp_q.push_back(16'h0200);
        exp_q.push_back(16'(NEED + int'(EXTRA_PULSES)));
        exp_q.push_back(16'(NEED));
        exp_q.push_back(16'(NEED));
        exp_q.push_back(16'h0000);
        exp_q.push_back({8'h00, word});
        exp_q.push_back(16'h0000);
        start = 1'b1;
        @(negedge clock);
        start = 1'b0;
        chk("busy", {15'h0000, status.busy}, 16'h0001);
        chk("done cleared", {15'h0000, status.done}, 16'h0000);
        repeat (3) @(negedge clock);
        chk("direct enable", {15'h0000, pins.direct_en}, {15'h0000, sync_variant});
        // Start and a pattern write while busy must both be ignored
        start = 1'b1;
        load.valid = 1'b1;
        load.addr = ta;
        load.data = 8'h00;
        @(negedge clock);
        start = 1'b0;
        load.valid = 1'b0;
        for (int i = 0; i < 80000 && !done_seen; i++)
            @(negedge clock);
        @(negedge clock);
        chk("finished", {15'h0000, done_seen}, 16'h0001);
        chk("idle pins", {pins.addr, pins.vcc_ver_lo | pins.vcc_ver_hi, pins.ce_n, pins.vcc_prog,
            pins.output_force_level}, {LAST_ADDR, 3'h2, 8'h00});
        results();
    end

    initial
    begin
        #450000;
        bad_count++;
        results();
    end
endmodule : fuse_prom_program_sequencer_tb
